// ### inc/cc_consts.svh
// Purpose: offsets, bit positions and reset values of the command channel
// Assumes: 8-bit register port, byte offsets as decoded by the block
// Notes:   definitions only
`ifndef CC_CONSTS_SVH
`define CC_CONSTS_SVH
`define CC_OFS_HOST_COUNT 8'hE8
`define CC_OFS_SG_DATA    8'hE9
`define CC_OFS_SG_PTR     8'hEA
`define CC_OFS_SG_CTRL    8'hEB
`define CC_OFS_SCB_DATA   8'hEC
`define CC_OFS_SCB_PTR    8'hED
`define CC_OFS_CB_CTRL    8'hEE
`define CC_BIT_DONE       7
`define CC_BIT_ENABLE     3
`define CC_BIT_DIR        2
`define CC_BIT_FLAG       1
`define CC_BIT_PTR_CLEAR  0
`define CC_PTR_RESET      8'h00
`define CC_COUNT_RESET    8'h00
`define CC_BYTE_ZERO      8'h00
`define CC_BUF_FULL       2'h2
`endif

// ### inc/cc_pkg.sv
// Purpose: types shared by the command channel files
// Assumes: nothing
// Notes:   register request and answer travel as packed structs
package cc_pkg;
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_type;
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } reg_rsp_type;
endpackage

// ### rtl/cc_byte_ram.sv
// Purpose: 256 x 8 byte memory, one write port, registered read
// Assumes: single clock
// Notes:   read data lags the read address by one edge
`timescale 1ns/1ps
module cc_byte_ram (
    input  wire logic       clk_sys_i,
    input  wire logic       we_i,
    input  wire logic [7:0] waddr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic [7:0] raddr_i,
    output logic      [7:0] rdata_o
);
    logic [7:0] mem [0:255];

    always_ff @(posedge clk_sys_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        rdata_o <= mem[raddr_i];
    end
endmodule

// ### rtl/cc_dma.sv
// Purpose: command channel DMA control, S/G and SCB SRAM access ports
// Assumes: register port and PCI master side on clk_sys_i
// Notes:   register reads answer two edges after the request
// Behaviour
// - s/g done when count zero, bus idle
// - s/g enable admits memory to s/g SRAM
// - clearing enable halts at byte boundary
// - enable bit reads back hardware acknowledge
// - each enable feeds only its own SRAM
// - s/g control bit 1 is plain storage
// - s/g pointer clear bit, self-clearing
// - writing 9h clears pointer and enables
// - cb pointer clear bit zeroes pointer
// - per DMA byte: pointer up, count down
// - SCB data port takes host reads, writes
// - s/g port usable during SCB DMA
// - cb pointer advances on every access
// - cb pointer cleared by both resets, bit
// - count down per byte, zero inhibits
// - s/g channel only inbound
// - direction bit selects SCB flow
// - cb done when count expires, outbound buffer empty
`timescale 1ns/1ps
`include "cc_consts.svh"
module cc_dma (
    input  wire logic                clk_sys_i,
    input  wire logic                reset_i,
    input  wire logic                soft_chip_reset_i,
    input  wire cc_pkg::reg_req_type reg_req_i,
    output cc_pkg::reg_rsp_type      reg_rsp_o,
    input  wire logic                pci_idle_i,
    input  wire logic                in_valid_i,
    input  wire logic [7:0]          in_data_i,
    output logic                     in_ready_o,
    output logic                     out_valid_o,
    output logic [7:0]               out_data_o,
    input  wire logic                out_ready_i,
    output logic                     dma_req_o,
    output logic                     dma_from_mem_o
);
    logic       clr;
    logic [7:0] count_ff, sg_ptr_ff, cb_ptr_ff, nxt_count;
    logic       sg_en_ff, sg_ack_ff, sg_flag_ff, sg_done_ff;
    logic       cb_en_ff, cb_ack_ff, cb_dir_ff, cb_done_ff;
    logic       nxt_sg_en, nxt_cb_en, nxt_cb_dir, nxt_in_sg, nxt_in_cb;
    logic       in_sel_sg_ff, in_take, in_sg_take, in_cb_take;
    logic       wr_cnt, wr_sgptr, wr_sgctl, wr_cbptr, wr_cbctl, wr_cbdata;
    logic       rd_sgdata, rd_cbdata;
    logic       out_issue, inflight_ff, pop, room;
    logic [1:0] buf_n_ff, nxt_buf_n, slot;
    logic [7:0] buf0_ff, buf1_ff;
    logic [7:0] sg_rdata, cb_rdata, cb_wdata;
    logic       rd_pend_ff;
    logic [7:0] rd_addr_ff;

    // bus reset and soft chip reset clear the same state
    assign clr = reset_i | soft_chip_reset_i;

    assign wr_cnt    = reg_req_i.wr && reg_req_i.addr == `CC_OFS_HOST_COUNT;
    assign wr_sgptr  = reg_req_i.wr && reg_req_i.addr == `CC_OFS_SG_PTR;
    assign wr_sgctl  = reg_req_i.wr && reg_req_i.addr == `CC_OFS_SG_CTRL;
    assign wr_cbptr  = reg_req_i.wr && reg_req_i.addr == `CC_OFS_SCB_PTR;
    assign wr_cbctl  = reg_req_i.wr && reg_req_i.addr == `CC_OFS_CB_CTRL;
    assign wr_cbdata = reg_req_i.wr && reg_req_i.addr == `CC_OFS_SCB_DATA;
    assign rd_sgdata = reg_req_i.rd && reg_req_i.addr == `CC_OFS_SG_DATA;
    assign rd_cbdata = reg_req_i.rd && reg_req_i.addr == `CC_OFS_SCB_DATA;

    assign in_take    = in_valid_i & in_ready_o;
    assign in_sg_take = in_take & in_sel_sg_ff;
    assign in_cb_take = in_take & ~in_sel_sg_ff;
    assign pop        = out_valid_o & out_ready_i;
    // conservative: a slot freed by this cycle's pop is not reused yet
    assign room       = ({1'b0, buf_n_ff} + {2'b00, inflight_ff}) < 3'h2;
    // outbound SCB read only with direction zero, count left
    assign out_issue  = cb_en_ff & ~cb_dir_ff & (count_ff != `CC_BYTE_ZERO) & room;

    // enable and pointer clear may arrive in one write
    assign nxt_sg_en  = wr_sgctl ? reg_req_i.wdata[`CC_BIT_ENABLE] : sg_en_ff;
    assign nxt_cb_en  = wr_cbctl ? reg_req_i.wdata[`CC_BIT_ENABLE] : cb_en_ff;
    // direction only follows the write while the channel is acknowledged idle
    assign nxt_cb_dir = (wr_cbctl && !cb_ack_ff) ? reg_req_i.wdata[`CC_BIT_DIR] : cb_dir_ff;

    always_comb begin
        nxt_count = count_ff;
        if (wr_cnt) begin
            nxt_count = reg_req_i.wdata;
        end else if (in_take | out_issue) begin
            nxt_count = count_ff - 8'h01;
        end
    end

    assign nxt_in_sg = nxt_sg_en & (nxt_count != `CC_BYTE_ZERO);
    assign nxt_in_cb = nxt_cb_en & nxt_cb_dir & (nxt_count != `CC_BYTE_ZERO);

    always_ff @(posedge clk_sys_i) begin
        if (clr) begin
            count_ff <= `CC_COUNT_RESET;
        end else begin
            count_ff <= nxt_count;
        end
    end

    // ready registered from next-cycle enable and count
    always_ff @(posedge clk_sys_i) begin
        if (clr) begin
            in_ready_o   <= 1'b0;
            in_sel_sg_ff <= 1'b0;
        end else begin
            in_ready_o   <= nxt_in_sg | nxt_in_cb;
            in_sel_sg_ff <= nxt_in_sg;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (clr) begin
            sg_en_ff   <= 1'b0;
            sg_flag_ff <= 1'b0;
        end else begin
            sg_en_ff   <= nxt_sg_en;
            sg_flag_ff <= wr_sgctl ? reg_req_i.wdata[`CC_BIT_FLAG] : sg_flag_ff;
        end
    end

    // ack stays up until the bus master has let go; cb ack also until no outbound byte is in flight or buffered
    always_ff @(posedge clk_sys_i) begin
        if (clr) begin
            sg_ack_ff <= 1'b0;
            cb_ack_ff <= 1'b0;
        end else begin
            sg_ack_ff <= sg_en_ff | (sg_ack_ff & ~pci_idle_i);
            cb_ack_ff <= cb_en_ff | (cb_ack_ff & (~pci_idle_i | inflight_ff
                         | (buf_n_ff != 2'h0)));
        end
    end

    // done flags; completion wins over a re-enable clear
    always_ff @(posedge clk_sys_i) begin
        if (clr) begin
            sg_done_ff <= 1'b0;
            cb_done_ff <= 1'b0;
        end else begin
            if (sg_en_ff && count_ff == `CC_BYTE_ZERO && pci_idle_i) begin
                sg_done_ff <= 1'b1;
            end else if (wr_sgctl && reg_req_i.wdata[`CC_BIT_ENABLE]) begin
                sg_done_ff <= 1'b0;
            end
            if (cb_en_ff && count_ff == `CC_BYTE_ZERO && !inflight_ff
                && buf_n_ff == 2'h0) begin
                cb_done_ff <= 1'b1;
            end else if (wr_cbctl && reg_req_i.wdata[`CC_BIT_ENABLE]) begin
                cb_done_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (clr) begin
            cb_en_ff  <= 1'b0;
            cb_dir_ff <= 1'b0;
        end else begin
            cb_en_ff  <= nxt_cb_en;
            cb_dir_ff <= nxt_cb_dir;
        end
    end

    // clear bit is never stored, so it reads back zero
    always_ff @(posedge clk_sys_i) begin
        if (clr) begin
            sg_ptr_ff <= `CC_PTR_RESET;
        end else if (wr_sgctl && reg_req_i.wdata[`CC_BIT_PTR_CLEAR]) begin
            sg_ptr_ff <= `CC_PTR_RESET;
        end else if (wr_sgptr) begin
            sg_ptr_ff <= reg_req_i.wdata;
        end else if (in_sg_take | rd_sgdata) begin
            // sequencer reads step the pointer too
            sg_ptr_ff <= sg_ptr_ff + 8'h01;
        end
    end

    // clear, reload, then step with natural wrap
    always_ff @(posedge clk_sys_i) begin
        if (clr) begin
            cb_ptr_ff <= `CC_PTR_RESET;
        end else if (wr_cbctl && reg_req_i.wdata[`CC_BIT_PTR_CLEAR]) begin
            cb_ptr_ff <= `CC_PTR_RESET;
        end else if (wr_cbptr) begin
            cb_ptr_ff <= reg_req_i.wdata;
        end else if (in_cb_take | out_issue | wr_cbdata | rd_cbdata) begin
            cb_ptr_ff <= cb_ptr_ff + 8'h01;
        end
    end

    // host writes share the port with inbound DMA, DMA first
    assign cb_wdata = in_cb_take ? in_data_i : reg_req_i.wdata;

    cc_byte_ram u_sg_ram (
        .clk_sys_i (clk_sys_i),
        .we_i      (in_sg_take),
        .waddr_i   (sg_ptr_ff),
        .wdata_i   (in_data_i),
        .raddr_i   (sg_ptr_ff),
        .rdata_o   (sg_rdata)
    );

    cc_byte_ram u_cb_ram (
        .clk_sys_i (clk_sys_i),
        .we_i      (in_cb_take | wr_cbdata),
        .waddr_i   (cb_ptr_ff),
        .wdata_i   (cb_wdata),
        .raddr_i   (cb_ptr_ff),
        .rdata_o   (cb_rdata)
    );

    // two-entry outbound buffer; head always in buf0
    assign nxt_buf_n = buf_n_ff + {1'b0, inflight_ff} - {1'b0, pop};
    assign slot      = buf_n_ff - {1'b0, pop};

    always_ff @(posedge clk_sys_i) begin
        if (clr) begin
            inflight_ff <= 1'b0;
            buf_n_ff    <= 2'h0;
            out_valid_o <= 1'b0;
        end else begin
            inflight_ff <= out_issue;
            buf_n_ff    <= nxt_buf_n;
            out_valid_o <= nxt_buf_n != 2'h0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (pop && buf_n_ff == `CC_BUF_FULL) begin
            buf0_ff <= buf1_ff;
        end
        if (inflight_ff && slot == 2'h0) begin
            buf0_ff <= cb_rdata;
        end
        if (inflight_ff && slot == 2'h1) begin
            buf1_ff <= cb_rdata;
        end
    end

    assign out_data_o = buf0_ff;

    always_ff @(posedge clk_sys_i) begin
        if (clr) begin
            dma_req_o      <= 1'b0;
            dma_from_mem_o <= 1'b0;
        end else begin
            dma_req_o      <= (nxt_sg_en | nxt_cb_en) & (nxt_count != `CC_BYTE_ZERO);
            dma_from_mem_o <= nxt_sg_en | nxt_cb_dir;
        end
    end

    // read pipeline: RAM data appear one edge after the request
    always_ff @(posedge clk_sys_i) begin
        if (clr) begin
            rd_pend_ff <= 1'b0;
            rd_addr_ff <= `CC_BYTE_ZERO;
        end else begin
            rd_pend_ff <= reg_req_i.rd;
            rd_addr_ff <= reg_req_i.addr;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (clr) begin
            reg_rsp_o <= '0;
        end else begin
            reg_rsp_o.valid <= rd_pend_ff;
            unique case (rd_addr_ff)
                `CC_OFS_HOST_COUNT: reg_rsp_o.data <= count_ff;
                `CC_OFS_SG_DATA:    reg_rsp_o.data <= sg_rdata;
                `CC_OFS_SG_PTR:     reg_rsp_o.data <= sg_ptr_ff;
                `CC_OFS_SCB_DATA:   reg_rsp_o.data <= cb_rdata;
                `CC_OFS_SCB_PTR:    reg_rsp_o.data <= cb_ptr_ff;
                `CC_OFS_SG_CTRL:    reg_rsp_o.data <= {sg_done_ff, 3'h0, sg_ack_ff,
                                                       1'b0, sg_flag_ff, 1'b0};
                `CC_OFS_CB_CTRL:    reg_rsp_o.data <= {cb_done_ff, 3'h0, cb_ack_ff,
                                                       cb_dir_ff, 2'h0};
                default:            reg_rsp_o.data <= `CC_BYTE_ZERO;
            endcase
        end
    end

    a_sg_done_set: assert property (@(posedge clk_sys_i) disable iff (clr)
        sg_en_ff && count_ff == 8'h00 && pci_idle_i |=> sg_done_ff)
        else $error("s/g done not set");
    a_sg_ready_gate: assert property (@(posedge clk_sys_i) disable iff (clr)
        in_ready_o && in_sel_sg_ff |-> sg_en_ff && count_ff != 8'h00)
        else $error("s/g intake without enable");
    a_ack_holds: assert property (@(posedge clk_sys_i) disable iff (clr)
        sg_ack_ff && !pci_idle_i |=> sg_ack_ff)
        else $error("ack dropped while bus busy");
    a_flag_store: assert property (@(posedge clk_sys_i) disable iff (clr)
        wr_sgctl |=> sg_flag_ff == $past(reg_req_i.wdata[1]))
        else $error("flag bit not stored");
    a_sg_clear: assert property (@(posedge clk_sys_i) disable iff (clr)
        wr_sgctl && reg_req_i.wdata[0] |=> sg_ptr_ff == 8'h00)
        else $error("s/g pointer not cleared");
    a_cb_step: assert property (@(posedge clk_sys_i) disable iff (clr)
        (in_cb_take || out_issue) && !wr_cnt && !wr_cbptr && !wr_cbctl
        |=> count_ff == $past(count_ff) - 8'h01 && cb_ptr_ff == $past(cb_ptr_ff) + 8'h01)
        else $error("count or pointer step wrong");
    a_cb_clear: assert property (@(posedge clk_sys_i) disable iff (clr)
        wr_cbctl && reg_req_i.wdata[0] |=> cb_ptr_ff == 8'h00)
        else $error("cb pointer not cleared");
    a_pio_step: assert property (@(posedge clk_sys_i) disable iff (clr)
        (rd_cbdata || wr_cbdata) && !in_cb_take && !out_issue && !wr_cbctl
        |=> cb_ptr_ff == $past(cb_ptr_ff) + 8'h01)
        else $error("port access did not step pointer");
    a_zero_stops: assert property (@(posedge clk_sys_i) disable iff (clr)
        count_ff == 8'h00 |-> !in_take ##1 !inflight_ff)
        else $error("transfer at zero count");
    a_out_dir: assert property (@(posedge clk_sys_i) disable iff (clr)
        inflight_ff |-> !$past(cb_dir_ff) ##1 out_valid_o)
        else $error("outbound byte with wrong direction");
    a_cb_done_set: assert property (@(posedge clk_sys_i) disable iff (clr)
        cb_en_ff && count_ff == 8'h00 && !inflight_ff && buf_n_ff == 2'h0 |=> cb_done_ff)
        else $error("cb done not set");
endmodule

// ### test/pci_mem_model.sv
// Purpose: PCI master stand-in that feeds and drains the command channel
// Assumes: one clock, design outputs registered
// Notes:   slow_i halves the byte rate on both sides
`timescale 1ns/1ps
module pci_mem_model (
    input  wire logic       clk_sys_i,
    input  wire logic       reset_i,
    input  wire logic       slow_i,
    input  wire logic [7:0] base_i,
    input  wire logic       dma_req_i,
    input  wire logic       dma_from_mem_i,
    input  wire logic       in_ready_i,
    output logic            in_valid_o,
    output logic      [7:0] in_data_o,
    output logic            pci_idle_o,
    input  wire logic       out_valid_i,
    input  wire logic [7:0] out_data_i,
    output logic            out_ready_o
);
    logic [7:0] idx_ff;
    logic       gap_ff;
    logic [7:0] rx_count_ff;
    logic [7:0] rx_mem [0:255];
    logic [7:0] nxt_idx;
    logic       nxt_valid;
    assign pci_idle_o = ~in_valid_o;
    always_comb begin
        nxt_idx = idx_ff + {7'h00, in_valid_o & in_ready_i};
        nxt_valid = dma_req_i & dma_from_mem_i & ~(slow_i & ~gap_ff);
    end
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            idx_ff <= 8'h00;
            gap_ff <= 1'b0;
            in_valid_o <= 1'b0;
            in_data_o <= 8'h00;
            out_ready_o <= 1'b0;
            rx_count_ff <= 8'h00;
        end else begin
            idx_ff <= dma_req_i ? nxt_idx : 8'h00;
            gap_ff <= slow_i & ~gap_ff;
            in_valid_o <= nxt_valid;
            // released line inverts each idle cycle, so the last byte shows again every other cycle
            in_data_o <= nxt_valid ? base_i + nxt_idx : ~in_data_o;
            out_ready_o <= ~slow_i | gap_ff;
            if (out_valid_i & out_ready_o) begin
                rx_mem[rx_count_ff] <= out_data_i;
                rx_count_ff <= rx_count_ff + 8'h01;
            end
        end
    end
endmodule

// ### test/testbench.sv
// Purpose: register-level tests of the command channel DMA block
// Assumes: answers come two edges after a read request
// Notes:   outputs are sampled at the edge, before that edge's updates
`timescale 1ns/1ps
module testbench;
    logic                clk_sys_i;
    logic                reset_i;
    logic                soft_chip_reset_i;
    cc_pkg::reg_req_type req;
    cc_pkg::reg_rsp_type rsp;
    logic                pci_idle;
    logic                in_valid;
    logic          [7:0] in_data;
    logic                in_ready;
    logic                out_valid;
    logic          [7:0] out_data;
    logic                out_ready;
    logic                dma_req;
    logic                dma_from_mem;
    logic                slow;
    logic          [7:0] base;
    logic          [7:0] d;
    logic          [7:0] d2;
    int                  mismatches;
    int                  comparisons;
    int                  cycles;
    int                  i;

    cc_dma cc_dma_inst (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
        .soft_chip_reset_i(soft_chip_reset_i), .reg_req_i(req), .reg_rsp_o(rsp),
        .pci_idle_i(pci_idle), .in_valid_i(in_valid), .in_data_i(in_data),
        .in_ready_o(in_ready), .out_valid_o(out_valid), .out_data_o(out_data),
        .out_ready_i(out_ready), .dma_req_o(dma_req), .dma_from_mem_o(dma_from_mem));
    pci_mem_model pci_mem_model_inst (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
        .slow_i(slow), .base_i(base), .dma_req_i(dma_req), .dma_from_mem_i(dma_from_mem),
        .in_ready_i(in_ready), .in_valid_o(in_valid), .in_data_o(in_data),
        .pci_idle_o(pci_idle), .out_valid_i(out_valid), .out_data_i(out_data),
        .out_ready_o(out_ready));

    always #12.5 clk_sys_i = ~clk_sys_i;

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        @(posedge clk_sys_i);
        req <= '0;
        @(posedge clk_sys_i);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        int n;
        v = 'x;
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk_sys_i);
        req <= '0;
        for (n = 0; n < 4; n++) begin
            @(posedge clk_sys_i);
            if (rsp.valid === 1'b1) begin
                v = rsp.data;
                break;
            end
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        rd(a, v);
        chk(v, exp);
    endtask
    // poll a control bit; giving up counts as a mismatch
    task automatic poll(input logic [7:0] a, input int b, input logic exp);
        logic [7:0] v;
        int n;
        for (n = 0; n < 300; n++) begin
            rd(a, v);
            if (v[b] === exp) begin
                break;
            end
        end
        chk({7'h00, v[b]}, {7'h00, exp});
    endtask

    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            close_out();
        end
    end

    initial begin
        clk_sys_i = 1'b0;
        reset_i = 1'b1;
        soft_chip_reset_i = 1'b0;
        req = '0;
        slow = 1'b0;
        base = 8'h00;
        mismatches = 0;
        comparisons = 0;
        cycles = 0;
        repeat (20) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        @(posedge clk_sys_i);
        rc(8'hED, 8'h00);
        rc(8'hEB, 8'h00);
        wr(8'hEB, 8'h02);
        rc(8'hEB, 8'h02);
        wr(8'hEB, 8'h00);
        wr(8'hED, 8'hFE);
        for (i = 0; i < 4; i++) wr(8'hEC, 8'hA0 + 8'(i));
        rc(8'hED, 8'h02);
        wr(8'hED, 8'hFE);
        for (i = 0; i < 4; i++) rc(8'hEC, 8'hA0 + 8'(i));
        rc(8'hED, 8'h02);
        wr(8'hEE, 8'h01);
        rc(8'hED, 8'h00);
        // control block inbound
        base <= 8'h50;
        wr(8'hE8, 8'h04);
        wr(8'hEE, 8'h0D);
        poll(8'hEE, 7, 1'b1);
        rc(8'hE8, 8'h00);
        rc(8'hED, 8'h04);
        wr(8'hEE, 8'h00);
        poll(8'hEE, 3, 1'b0);
        wr(8'hED, 8'h00);
        for (i = 0; i < 4; i++) rc(8'hEC, 8'h50 + 8'(i));
        // s/g fetch: nothing may go out, cb pointer must stay put
        base <= 8'h70;
        wr(8'hEA, 8'h05);
        wr(8'hE8, 8'h03);
        wr(8'hEB, 8'h09);
        poll(8'hEB, 7, 1'b1);
        rc(8'hEA, 8'h03);
        rc(8'hED, 8'h04);
        chk(pci_mem_model_inst.rx_count_ff, 8'h00);
        wr(8'hEB, 8'h00);
        poll(8'hEB, 3, 1'b0);
        // cb outbound with stalling drain; s/g port read while it runs
        slow <= 1'b1;
        wr(8'hE8, 8'h03);
        wr(8'hEE, 8'h09);
        wr(8'hEA, 8'h00);
        for (i = 0; i < 3; i++) rc(8'hE9, 8'h70 + 8'(i));
        poll(8'hEE, 7, 1'b1);
        wr(8'hEE, 8'h00);
        poll(8'hEE, 3, 1'b0);
        chk(pci_mem_model_inst.rx_count_ff, 8'h03);
        for (i = 0; i < 3; i++) chk(pci_mem_model_inst.rx_mem[i], 8'h50 + 8'(i));
        // abort in mid-transfer: pointer and count stay consistent
        wr(8'hE8, 8'h08);
        wr(8'hEB, 8'h09);
        repeat (4) @(posedge clk_sys_i);
        wr(8'hEB, 8'h00);
        poll(8'hEB, 3, 1'b0);
        rd(8'hEA, d);
        rd(8'hE8, d2);
        chk(d + d2, 8'h08);
        slow <= 1'b0;
        wr(8'hE8, 8'h00);
        wr(8'hEE, 8'h0D);
        repeat (6) @(posedge clk_sys_i);
        chk({5'h00, dma_from_mem, in_ready, dma_req}, 8'h04);
        wr(8'hEE, 8'h00);
        wr(8'hED, 8'h33);
        soft_chip_reset_i <= 1'b1;
        @(posedge clk_sys_i);
        soft_chip_reset_i <= 1'b0;
        @(posedge clk_sys_i);
        rc(8'hED, 8'h00);
        close_out();
    end
endmodule
